// [src/ccsr_pkg.sv]
// Constants and types for the core status register file
package ccsr_pkg;

  // ----------------------------------------------------------------
  // Register addresses in the special-function space
  // ----------------------------------------------------------------
  localparam logic [7:0] STACK_TOP_POINTER_ADDR   = 8'h81;
  localparam logic [7:0] DATA_POINTER_LOW_ADDR    = 8'h82;
  localparam logic [7:0] DATA_POINTER_HIGH_ADDR   = 8'h83;
  localparam logic [7:0] PROGRAM_STATUS_WORD_ADDR = 8'hD0;
  localparam logic [7:0] ARITH_PRIMARY_REG_ADDR   = 8'hE0;
  localparam logic [7:0] SECOND_OPERAND_REG_ADDR  = 8'hF0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STACK_TOP_POINTER_RST = 8'h07;
  localparam logic [7:0] BYTE_ZERO_RST         = 8'h00;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int CARRY_BIT      = 7;
  localparam int HALF_CARRY_BIT = 6;
  localparam int USER_ZERO_BIT  = 5;
  localparam int BANK_HI_BIT    = 4;
  localparam int BANK_LO_BIT    = 3;
  localparam int ARITH_ERR_BIT  = 2;
  localparam int USER_ONE_BIT   = 1;
  localparam int PARITY_BIT     = 0;

  // Largest product that fits one byte
  localparam logic [15:0] PRODUCT_BYTE_MAX = 16'h00FF;

  // ----------------------------------------------------------------
  // Arithmetic operation codes from the datapath
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCSR_OP_NONE,
    CCSR_OP_ADD,
    CCSR_OP_ADDC,
    CCSR_OP_SUBB,
    CCSR_OP_MUL,
    CCSR_OP_DIV
  } ccsr_op_t;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccsr_sfr_req_t;

  // Datapath requests to the core registers
  typedef struct packed {
    ccsr_op_t   op;
    logic [7:0] opnd;
    logic       push;
  } ccsr_core_req_t;

endpackage : ccsr_pkg

// [src/ccsr_core_regs.sv]
// Core status registers: stack, data pointer, status word, arithmetic
//
// Overview of operation
// - Stack pointer increments before each pushed byte.
// - Stack pointer resets to 0x07.
// - Low and high bytes form 16-bit pointer.
// - Carry set on carry/borrow, else cleared.
// - Half-carry set on nibble carry/borrow.
// - Two user flags only software changes.
// - Bank select picks one of four banks.
// - Overflow set on signed add/subtract overflow.
// - Overflow set when product exceeds 255.
// - Overflow set on divide by zero.
// - Overflow cleared by clean arithmetic completion.
// - Parity flag follows odd ones in primary.
// - Secondary register holds second operand/result.
`timescale 1ns/1ps
`default_nettype none

module ccsr_core_regs
  import ccsr_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic           REF_CLK,
  input  wire logic           RST,
  // Special-function register access
  input  wire ccsr_sfr_req_t  SFR_REQ,
  output var  logic [7:0]     SFR_RDATA,
  // Datapath requests
  input  wire ccsr_core_req_t CORE_REQ,
  // Register views for the rest of the core
  output var  logic [7:0]     STACK_TOP_POINTER,
  output var  logic [15:0]    INDIRECT_ADDRESS_POINTER,
  output var  logic [4:0]     BANK_BASE,
  output var  logic [7:0]     PROGRAM_STATUS_WORD,
  output var  logic [7:0]     ARITH_PRIMARY_REG,
  output var  logic [7:0]     SECOND_OPERAND_REG
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DATA_W != 8) begin : g_width_check
    $error("ccsr_core_regs supports only an 8-bit data width");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] stack_top_pointer;   // Top of stack address
  logic [7:0] data_pointer_low;    // Pointer low byte
  logic [7:0] data_pointer_high;   // Pointer high byte
  logic       carry_flag;          // Carry / borrow
  logic       half_carry_flag;     // Nibble carry / borrow
  logic       user_flag_zero;      // Software flag
  logic       user_flag_one;       // Software flag
  logic [1:0] bank_select;         // Working bank
  logic       arith_error_flag;    // Overflow
  logic [7:0] arith_primary_reg;   // Primary accumulator
  logic [7:0] second_operand_reg;  // Secondary accumulator

  // ----------------------------------------------------------------
  // Arithmetic results
  // ----------------------------------------------------------------
  logic [7:0]  next_primary;       // Result for primary
  logic [7:0]  next_second;        // Result for secondary
  logic        next_carry;         // Carry result
  logic        next_half;          // Half-carry result
  logic        next_err;           // Overflow result
  logic        upd_carry;          // Op touches carry/half
  logic        upd_err;            // Op touches overflow
  logic        op_active;          // Any arithmetic op
  logic [8:0]  sum9;               // Full byte sum/difference
  logic [4:0]  sum5;               // Low nibble sum/difference
  logic [15:0] product;            // Multiply result
  logic        cin;                // Carry in

  // ----------------------------------------------------------------
  // Status word assembly, used for read and output
  // ----------------------------------------------------------------
  function automatic logic [7:0] pack_psw(
    input logic       cy,
    input logic       hc,
    input logic       f0,
    input logic [1:0] bs,
    input logic       ov,
    input logic       f1,
    input logic [7:0] acc
  );
    logic [7:0] w;
    w                 = BYTE_ZERO_RST;
    w[CARRY_BIT]      = cy;
    w[HALF_CARRY_BIT] = hc;
    w[USER_ZERO_BIT]  = f0;
    w[BANK_HI_BIT:BANK_LO_BIT] = bs;
    w[ARITH_ERR_BIT]  = ov;
    w[USER_ONE_BIT]   = f1;
    w[PARITY_BIT]     = ^acc;
    return w;
  endfunction : pack_psw

  // ----------------------------------------------------------------
  // Combinational arithmetic per operation
  // ----------------------------------------------------------------
  always_comb begin
    cin          = 1'b0;
    sum9         = 9'h000;
    sum5         = 5'h00;
    product      = 16'h0000;
    next_primary = arith_primary_reg;
    next_second  = second_operand_reg;
    next_carry   = 1'b0;
    next_half    = 1'b0;
    next_err     = 1'b0;
    upd_carry    = 1'b0;
    upd_err      = 1'b0;
    op_active    = (CORE_REQ.op != CCSR_OP_NONE);
    unique case (CORE_REQ.op)
      CCSR_OP_NONE: begin
        // Nothing to compute
      end
      CCSR_OP_ADD, CCSR_OP_ADDC: begin
        cin  = (CORE_REQ.op == CCSR_OP_ADDC) ? carry_flag : 1'b0;
        sum9 = {1'b0, arith_primary_reg} + {1'b0, CORE_REQ.opnd}
               + {8'h00, cin};
        sum5 = {1'b0, arith_primary_reg[3:0]} + {1'b0, CORE_REQ.opnd[3:0]}
               + {4'h0, cin};
        next_primary = sum9[7:0];
        next_carry   = sum9[8];
        next_half    = sum5[4];
        // Same-sign operands giving other-sign result
        next_err = (arith_primary_reg[7] == CORE_REQ.opnd[7]) &&
                   (sum9[7] != arith_primary_reg[7]);
        upd_carry = 1'b1;
        upd_err   = 1'b1;
      end
      CCSR_OP_SUBB: begin
        cin  = carry_flag;
        sum9 = {1'b0, arith_primary_reg} - {1'b0, CORE_REQ.opnd}
               - {8'h00, cin};
        sum5 = {1'b0, arith_primary_reg[3:0]} - {1'b0, CORE_REQ.opnd[3:0]}
               - {4'h0, cin};
        next_primary = sum9[7:0];
        next_carry   = sum9[8];
        next_half    = sum5[4];
        // Different-sign operands, result sign differs from minuend
        next_err = (arith_primary_reg[7] != CORE_REQ.opnd[7]) &&
                   (sum9[7] != arith_primary_reg[7]);
        upd_carry = 1'b1;
        upd_err   = 1'b1;
      end
      CCSR_OP_MUL: begin
        // Primary times secondary; high byte lands in secondary
        product      = {8'h00, arith_primary_reg} *
                       {8'h00, second_operand_reg};
        next_primary = product[7:0];
        next_second  = product[15:8];
        next_err     = (product > PRODUCT_BYTE_MAX);
        next_carry   = 1'b0;
        upd_carry    = 1'b1;
        upd_err      = 1'b1;
      end
      CCSR_OP_DIV: begin
        // Quotient to primary, remainder to secondary
        if (second_operand_reg == BYTE_ZERO_RST) begin
          next_err = 1'b1;
        end else begin
          next_primary = arith_primary_reg / second_operand_reg;
          next_second  = arith_primary_reg % second_operand_reg;
        end
        next_carry = 1'b0;
        upd_carry  = 1'b1;
        upd_err    = 1'b1;
      end
      default: begin
        // Illegal op code: no effect
        op_active = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Software write strobes
  // ----------------------------------------------------------------
  logic wr_sp;   // Store to stack pointer
  logic wr_dpl;  // Store to pointer low byte
  logic wr_dph;  // Store to pointer high byte
  logic wr_psw;  // Store to status word
  logic wr_acc;  // Store to primary
  logic wr_b;    // Store to secondary

  // One decoder shared by every register's write strobe
  function automatic logic write_hit(
    input ccsr_sfr_req_t req,
    input logic [7:0]    target
  );
    return req.wr && (req.addr == target);
  endfunction : write_hit

  assign wr_sp  = write_hit(SFR_REQ, STACK_TOP_POINTER_ADDR);
  assign wr_dpl = write_hit(SFR_REQ, DATA_POINTER_LOW_ADDR);
  assign wr_dph = write_hit(SFR_REQ, DATA_POINTER_HIGH_ADDR);
  assign wr_psw = write_hit(SFR_REQ, PROGRAM_STATUS_WORD_ADDR);
  assign wr_acc = write_hit(SFR_REQ, ARITH_PRIMARY_REG_ADDR);
  assign wr_b   = write_hit(SFR_REQ, SECOND_OPERAND_REG_ADDR);

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      stack_top_pointer <= STACK_TOP_POINTER_RST;
    end else if (CORE_REQ.push) begin
      // Pre-increment so pointer names the byte now written
      stack_top_pointer <= stack_top_pointer + 8'h01;
    end else if (wr_sp) begin
      // Software store only when no push
      stack_top_pointer <= SFR_REQ.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Data pointer bytes
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      data_pointer_low  <= BYTE_ZERO_RST;
      data_pointer_high <= BYTE_ZERO_RST;
    end else begin
      if (wr_dpl) begin
        data_pointer_low <= SFR_REQ.wdata;
      end
      if (wr_dph) begin
        data_pointer_high <= SFR_REQ.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word flags; hardware update beats a same-cycle write
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      carry_flag       <= 1'b0;
      half_carry_flag  <= 1'b0;
      user_flag_zero   <= 1'b0;
      user_flag_one    <= 1'b0;
      bank_select      <= 2'b00;
      arith_error_flag <= 1'b0;
    end else begin
      if (wr_psw) begin
        // Parity bit of the write data is dropped
        carry_flag       <= SFR_REQ.wdata[CARRY_BIT];
        half_carry_flag  <= SFR_REQ.wdata[HALF_CARRY_BIT];
        user_flag_zero   <= SFR_REQ.wdata[USER_ZERO_BIT];
        user_flag_one    <= SFR_REQ.wdata[USER_ONE_BIT];
        bank_select      <= SFR_REQ.wdata[BANK_HI_BIT:BANK_LO_BIT];
        arith_error_flag <= SFR_REQ.wdata[ARITH_ERR_BIT];
      end
      if (op_active && upd_carry) begin
        carry_flag      <= next_carry;
        half_carry_flag <= next_half;
      end
      if (op_active && upd_err) begin
        arith_error_flag <= next_err;
      end
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic registers; operation beats a same-cycle write
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      arith_primary_reg  <= BYTE_ZERO_RST;
      second_operand_reg <= BYTE_ZERO_RST;
    end else if (op_active) begin
      arith_primary_reg  <= next_primary;
      second_operand_reg <= next_second;
    end else begin
      if (wr_acc) begin
        arith_primary_reg <= SFR_REQ.wdata;
      end
      if (wr_b) begin
        second_operand_reg <= SFR_REQ.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs, one cycle after the state
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      STACK_TOP_POINTER        <= STACK_TOP_POINTER_RST;
      INDIRECT_ADDRESS_POINTER <= {BYTE_ZERO_RST, BYTE_ZERO_RST};
      BANK_BASE                <= 5'h00;
      PROGRAM_STATUS_WORD      <= BYTE_ZERO_RST;
      ARITH_PRIMARY_REG        <= BYTE_ZERO_RST;
      SECOND_OPERAND_REG       <= BYTE_ZERO_RST;
    end else begin
      STACK_TOP_POINTER        <= stack_top_pointer;
      INDIRECT_ADDRESS_POINTER <= {data_pointer_high,
                                   data_pointer_low};
      BANK_BASE                <= {bank_select, 3'b000};
      PROGRAM_STATUS_WORD      <= pack_psw(carry_flag, half_carry_flag,
                                    user_flag_zero, bank_select,
                                    arith_error_flag, user_flag_one,
                                    arith_primary_reg);
      ARITH_PRIMARY_REG        <= arith_primary_reg;
      SECOND_OPERAND_REG       <= second_operand_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered; unmapped addresses read zero
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SFR_RDATA <= BYTE_ZERO_RST;
    end else if (SFR_REQ.rd) begin
      unique case (SFR_REQ.addr)
        STACK_TOP_POINTER_ADDR:   SFR_RDATA <= stack_top_pointer;
        DATA_POINTER_LOW_ADDR:    SFR_RDATA <= data_pointer_low;
        DATA_POINTER_HIGH_ADDR:   SFR_RDATA <= data_pointer_high;
        PROGRAM_STATUS_WORD_ADDR: SFR_RDATA <= pack_psw(carry_flag,
                                    half_carry_flag, user_flag_zero,
                                    bank_select, arith_error_flag,
                                    user_flag_one, arith_primary_reg);
        ARITH_PRIMARY_REG_ADDR:   SFR_RDATA <= arith_primary_reg;
        SECOND_OPERAND_REG_ADDR:  SFR_RDATA <= second_operand_reg;
        default:                  SFR_RDATA <= BYTE_ZERO_RST;
      endcase
    end
  end

endmodule : ccsr_core_regs

`default_nettype wire

// [verification/ccsr_core_regs_asserts.sv]
// Concurrent checks on the core status register ports
`timescale 1ns/1ps
`default_nettype none

module ccsr_core_regs_asserts
  import ccsr_pkg::*;
(
  // Clock and reset
  input wire logic           REF_CLK,
  input wire logic           RST,
  // Requests and read data
  input wire ccsr_sfr_req_t  SFR_REQ,
  input wire logic [7:0]     SFR_RDATA,
  input wire ccsr_core_req_t CORE_REQ,
  // Register views
  input wire logic [7:0]     STACK_TOP_POINTER,
  input wire logic [15:0]    INDIRECT_ADDRESS_POINTER,
  input wire logic [4:0]     BANK_BASE,
  input wire logic [7:0]     PROGRAM_STATUS_WORD,
  input wire logic [7:0]     ARITH_PRIMARY_REG,
  input wire logic [7:0]     SECOND_OPERAND_REG
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // Anything that moves the stack pointer this cycle
  wire logic sp_touch = CORE_REQ.push ||
    (SFR_REQ.wr && SFR_REQ.addr == STACK_TOP_POINTER_ADDR);

  // ----------------------------------------------------------------
  // Sequences: an operation, then the cycle its operands are visible
  // ----------------------------------------------------------------
  sequence s_add;
    CORE_REQ.op == CCSR_OP_ADD ##1 1'b1;
  endsequence
  sequence s_mul;
    CORE_REQ.op == CCSR_OP_MUL ##1 1'b1;
  endsequence
  sequence s_div_zero;
    CORE_REQ.op == CCSR_OP_DIV ##1 SECOND_OPERAND_REG == 8'h00;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_reset_sp;
    $fell(RST) |-> STACK_TOP_POINTER == 8'h07 &&
      PROGRAM_STATUS_WORD == 8'h00;
  endproperty
  property p_push;
    !sp_touch ##1 CORE_REQ.push |=> ##1
      STACK_TOP_POINTER == $past(STACK_TOP_POINTER) + 8'h01;
  endproperty
  property p_parity;
    PROGRAM_STATUS_WORD[PARITY_BIT] == ^ARITH_PRIMARY_REG;
  endproperty
  property p_bank;
    BANK_BASE == {PROGRAM_STATUS_WORD[4:3], 3'b000};
  endproperty
  property p_rd_acc;
    SFR_REQ.rd && SFR_REQ.addr == ARITH_PRIMARY_REG_ADDR |=>
      SFR_RDATA == ARITH_PRIMARY_REG;
  endproperty
  property p_rd_unmapped;
    SFR_REQ.rd && !(SFR_REQ.addr inside {8'h81, 8'h82, 8'h83, 8'hD0,
      8'hE0, 8'hF0}) |=> SFR_RDATA == 8'h00;
  endproperty
  property p_dpl;
    SFR_REQ.wr && SFR_REQ.addr == DATA_POINTER_LOW_ADDR |=> ##1
      INDIRECT_ADDRESS_POINTER[7:0] == $past(SFR_REQ.wdata, 2);
  endproperty
  property p_div_zero;
    s_div_zero |=> PROGRAM_STATUS_WORD[ARITH_ERR_BIT] &&
      $stable(ARITH_PRIMARY_REG) && $stable(SECOND_OPERAND_REG);
  endproperty
  property p_mul;
    s_mul |=> {SECOND_OPERAND_REG, ARITH_PRIMARY_REG} ==
      16'($past(ARITH_PRIMARY_REG)) * 16'($past(SECOND_OPERAND_REG)) &&
      PROGRAM_STATUS_WORD[ARITH_ERR_BIT] == (SECOND_OPERAND_REG != 8'h00);
  endproperty
  property p_add;
    s_add |=> {PROGRAM_STATUS_WORD[CARRY_BIT], ARITH_PRIMARY_REG} ==
      9'($past(ARITH_PRIMARY_REG)) + 9'($past(CORE_REQ.opnd, 2));
  endproperty

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_sp: assert property (p_reset_sp)
    else $error("stack pointer not at reset value");
  a_push: assert property (p_push)
    else $error("push did not add one to stack pointer");
  a_parity: assert property (p_parity)
    else $error("parity flag wrong");
  a_bank: assert property (p_bank)
    else $error("bank base wrong");
  a_rd_acc: assert property (p_rd_acc)
    else $error("primary read data wrong");
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  a_dpl: assert property (p_dpl)
    else $error("pointer low byte not written");
  a_div_zero: assert property (p_div_zero)
    else $error("divide by zero handled wrongly");
  a_mul: assert property (p_mul)
    else $error("multiply result or overflow wrong");
  a_add: assert property (p_add)
    else $error("add sum or carry wrong");
endmodule : ccsr_core_regs_asserts

bind ccsr_core_regs ccsr_core_regs_asserts i_ccsr_core_regs_asserts (
  .REF_CLK(REF_CLK), .RST(RST), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
  .CORE_REQ(CORE_REQ), .STACK_TOP_POINTER(STACK_TOP_POINTER),
  .INDIRECT_ADDRESS_POINTER(INDIRECT_ADDRESS_POINTER),
  .BANK_BASE(BANK_BASE), .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD),
  .ARITH_PRIMARY_REG(ARITH_PRIMARY_REG),
  .SECOND_OPERAND_REG(SECOND_OPERAND_REG));

`default_nettype wire

// [verification/ccsr_core_regs_tb.sv]
// Self-checking bench for the core status register file
`timescale 1ns/1ps
`default_nettype none

module ccsr_core_regs_tb
  import ccsr_pkg::*;
;
  logic           ref_clk;   // 40 MHz clock
  logic           rst;       // Reset, active high
  ccsr_sfr_req_t  sfr_req;   // Register access
  ccsr_core_req_t core_req;  // Datapath request
  logic [7:0]     sfr_rdata, sp_out, psw_out, acc_out, b_out;
  logic [15:0]    indirect_address_pointer_out;  // Combined pointer view
  logic [4:0]     bank_base; // Bank base address
  int             bad_count, samples_checked;
  int             b;

  // Reset image: address and expected value, last one unmapped
  logic [7:0] rst_addr[7] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0,
                              8'h84};
  logic [7:0] rst_val[7]  = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00};
  // Arithmetic table: op, operand, primary, secondary, expected results
  ccsr_op_t   t_op[8]   = '{CCSR_OP_ADD, CCSR_OP_ADD, CCSR_OP_SUBB,
    CCSR_OP_ADDC, CCSR_OP_MUL, CCSR_OP_MUL, CCSR_OP_DIV, CCSR_OP_DIV};
  logic [7:0] t_opnd[8] = '{8'h01, 8'h80, 8'h01, 8'h01, 8'h00, 8'h00,
                            8'h00, 8'h00};
  logic [7:0] t_a[8]    = '{8'h7F, 8'h80, 8'h00, 8'hFE, 8'h10, 8'h0F,
                            8'h07, 8'h07};
  logic [7:0] t_b[8]    = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h11,
                            8'h02, 8'h00};
  logic [7:0] t_acc[8]  = '{8'h80, 8'h00, 8'hFE, 8'h00, 8'h00, 8'hFF,
                            8'h03, 8'h07};
  logic [7:0] t_br[8]   = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00,
                            8'h01, 8'h00};
  logic [7:0] t_psw[8]  = '{8'h67, 8'hA6, 8'hE3, 8'hE2, 8'h26, 8'h22,
                            8'h22, 8'h27};

  // ----------------------------------------------------------------
  // Design under test
  // ----------------------------------------------------------------
  ccsr_core_regs #(.DATA_W(8)) i_ccsr_core_regs (
    .REF_CLK(ref_clk), .RST(rst), .SFR_REQ(sfr_req),
    .SFR_RDATA(sfr_rdata), .CORE_REQ(core_req),
    .STACK_TOP_POINTER(sp_out), .INDIRECT_ADDRESS_POINTER(indirect_address_pointer_out),
    .BANK_BASE(bank_base), .PROGRAM_STATUS_WORD(psw_out),
    .ARITH_PRIMARY_REG(acc_out), .SECOND_OPERAND_REG(b_out));

  // Clock generation
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Tasks; drive, wr, rd and op each drive one full cycle from a falling edge
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic drive(input ccsr_sfr_req_t s, input ccsr_core_req_t c);
    sfr_req = s;
    core_req = c;
    @(negedge ref_clk);
  endtask : drive

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    drive('{wr: 1'b1, rd: 1'b0, addr: a, wdata: d}, '0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    drive('{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00}, '0);
    chk({8'h00, sfr_rdata}, {8'h00, exp});
  endtask : rd

  task automatic op(input ccsr_op_t o, input logic [7:0] d,
                    input logic p);
    drive('0, '{op: o, opnd: d, push: p});
  endtask : op

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run of about 100 cycles
  initial begin
    repeat (1000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    sfr_req = '0;
    core_req = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    // Reset image, unmapped address reads zero
    for (int i = 0; i < 7; i++) rd(rst_addr[i], rst_val[i]);
    // Back-to-back pushes, then wrap past the top
    op(CCSR_OP_NONE, 8'h00, 1'b1);
    op(CCSR_OP_NONE, 8'h00, 1'b1);
    rd(STACK_TOP_POINTER_ADDR, 8'h09);
    chk({8'h00, sp_out}, 16'h0009);
    wr(STACK_TOP_POINTER_ADDR, 8'hFF);
    op(CCSR_OP_NONE, 8'h00, 1'b1);
    rd(STACK_TOP_POINTER_ADDR, 8'h00);
    // Pointer bytes combine high over low
    wr(DATA_POINTER_LOW_ADDR, 8'h34);
    wr(DATA_POINTER_HIGH_ADDR, 8'h12);
    drive('0, '0);
    chk(indirect_address_pointer_out, 16'h1234);
    // Parity bit ignores software
    wr(PROGRAM_STATUS_WORD_ADDR, 8'hFF);
    rd(PROGRAM_STATUS_WORD_ADDR, 8'hFE);
    // Every bank select value
    for (b = 0; b < 4; b++) begin
      wr(PROGRAM_STATUS_WORD_ADDR, {3'b000, b[1:0], 3'b000});
      drive('0, '0);
      chk({11'h000, bank_base}, {11'h000, b[1:0], 3'b000});
    end
    // Arithmetic table with both user flags held set
    wr(PROGRAM_STATUS_WORD_ADDR, 8'h22);
    for (int i = 0; i < 8; i++) begin
      wr(ARITH_PRIMARY_REG_ADDR, t_a[i]);
      wr(SECOND_OPERAND_REG_ADDR, t_b[i]);
      op(t_op[i], t_opnd[i], 1'b0);
      rd(ARITH_PRIMARY_REG_ADDR, t_acc[i]);
      rd(SECOND_OPERAND_REG_ADDR, t_br[i]);
      rd(PROGRAM_STATUS_WORD_ADDR, t_psw[i]);
      chk({b_out, acc_out}, {t_br[i], t_acc[i]});
    end
    chk({8'h00, psw_out}, 16'h0027);
    // Operation beats a store to primary in the same cycle, with a push alongside
    drive('{wr: 1'b1, rd: 1'b0, addr: ARITH_PRIMARY_REG_ADDR, wdata: 8'h55},
          '{op: CCSR_OP_ADD, opnd: 8'h01, push: 1'b1});
    rd(ARITH_PRIMARY_REG_ADDR, 8'h08);
    rd(STACK_TOP_POINTER_ADDR, 8'h01);
    rd(PROGRAM_STATUS_WORD_ADDR, 8'h23);
    end_sim();
  end
endmodule : ccsr_core_regs_tb

`default_nettype wire
